// ==== verilog/dpx_page_dma.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R01 - Byte level: page on A23-16, counter low
// R02 - Word level: counter A16-1, page A23-17
// R03 - Word level: page bit0 ignored, A0 zero
// R04 - Counter never carries into page; wraps
// R05 - Page spans 64K bytes or 64K words (128K bytes)
// R06 - One 8-bit page per level, none level4
// R07 - Levels 0-3 pages at 87h,83h,81h,82h
// R08 - Levels 5-7 pages at 8Bh,89h,8Ah
// R09 - Page registers readable; software may not rely
// R10 - Software setup order ends with page write
// R11 - Then board enables, unmask channel last
// R12 - Request output floats until board enabled
// R13 - Software enables board before channel unmask
// R14 - Masked channel keeps request until unmasked
// R15 - Request raises hold now; transfer after grant
// R16 - Granted transfer lasts five DMA clocks
// R17 - Timer rising edge makes a request
// R18 - Acknowledge low at request, high when done
// R19 - Peripheral may pace through request handshake
// R20 - Software parks timer slow during setup
// R21 - Page keeps value until rewritten; resets zero
module dpx_page_dma
	import dpx_pkg::*;
#(
	parameter int FIFO_W = 16,
	parameter int FIFO_D = 16
) (
	// ----------------------------------------
	// Clock and reset
	// ----------------------------------------
	input  wire logic          MCLK,
	input  wire logic          RST,
	// ----------------------------------------
	// Host I/O port
	// ----------------------------------------
	input  wire dpx_io_t       IO_REQ,
	output logic [7:0]         IO_RDATA,
	// ----------------------------------------
	// Address counter load
	// ----------------------------------------
	input  wire logic          ADDR_LOAD,
	input  wire logic [15:0]   ADDR_BASE,
	// ----------------------------------------
	// Bus hold handshake
	// ----------------------------------------
	output logic               HOLD_REQ,
	input  wire logic          HOLD_ACK,
	// ----------------------------------------
	// Request line, two signals
	// ----------------------------------------
	output logic               DREQ_O,
	output logic               DREQ_OE_N,
	// ----------------------------------------
	// Memory write
	// ----------------------------------------
	output dpx_mem_t           MEM,
	// ----------------------------------------
	// Peripheral side
	// ----------------------------------------
	input  wire logic          TIMER_OUT,
	input  wire logic          TRANSFER_REQUEST_IN,
	output logic               TRANSFER_ACKNOWLEDGE_OUT_N,
	input  wire logic          PERIPH_VALID,
	input  wire logic [15:0]   PERIPH_DATA,
	output logic               PERIPH_READY
);

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [7:0]  ctrl_r;
	wire         dma_en     = ctrl_r[CTRL_EN_BIT];
	wire         timer_mode = ctrl_r[CTRL_TIMER_BIT];
	wire         ch_mask    = ctrl_r[CTRL_MASK_BIT];
	wire [2:0]   level      = ctrl_r[CTRL_LVL_LSB +: 3];
	wire         word_lvl   = level[2];

	wire [3:0]   wr_dec     = dpx_io_level(IO_REQ.addr);
	wire [3:0]   rd_dec     = dpx_io_level(IO_REQ.addr);
	wire         page_wr    = IO_REQ.wr && wr_dec[3];
	wire         ctrl_wr    = IO_REQ.wr && (IO_REQ.addr == IO_CTRL);

	always_ff @(posedge MCLK)
	begin
		if (RST)
			ctrl_r <= CTRL_RESET;
		else if (ctrl_wr)
			ctrl_r <= IO_REQ.wdata;
	end

	// ----------------------------------------
	// Page registers
	// ----------------------------------------
	logic [7:0] page_w [8];
	logic [63:0] pages_flat;

	genvar g;
	generate
		for (g = 0; g < 8; g++)
		begin : g_page
			if (g == 4)
			begin : g_none
				// Cascade level carries no page
				assign page_w[g] = PAGE_RESET; // R06
			end
			else
			begin : g_reg
				logic [7:0] pg_r;
				always_ff @(posedge MCLK)
				begin
					if (RST)
						pg_r <= PAGE_RESET; // R21
					else if (page_wr && wr_dec[2:0] == 3'(g))
						pg_r <= IO_REQ.wdata; // R07 R08
				end
				assign page_w[g] = pg_r;
			end
			assign pages_flat[g*8 +: 8] = page_w[g];
		end
	endgenerate

	wire [7:0] page_sel = page_w[level];

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	logic src_prev_r;
	logic pend_r;
	logic ack_n_r;
	wire  req_src  = timer_mode ? TIMER_OUT : TRANSFER_REQUEST_IN; // R17 R19
	wire  req_edge = req_src && !src_prev_r;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	dpx_state_t state_r;
	dpx_state_t state_nxt;
	logic [6:0] cnt_r;
	logic [15:0] addr_cnt_r;
	dpx_mem_t   mem_r;

	logic        f_valid;
	logic [15:0] f_data;

	// Stalls on an empty buffer, so a request never moves stale data
	wire svc_ok = pend_r && !ch_mask && dma_en && f_valid
		&& (level != CASCADE_LEVEL);
	wire grant  = (state_r == ST_HOLD) && HOLD_ACK;
	wire fin    = (state_r == ST_XFER) && (cnt_r == 7'h00);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (svc_ok) state_nxt = ST_HOLD;
			ST_HOLD: if (HOLD_ACK) state_nxt = ST_XFER; // R15
			ST_XFER: if (fin) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Hold goes up in the same cycle svc_ok is seen, at the soonest one clock after the request edge
	assign HOLD_REQ = (state_r != ST_IDLE) || svc_ok; // R15

	// ----------------------------------------
	// Address forming
	// ----------------------------------------
	// Word page: 128K span, A0 forced low, page bit 0 dropped
	wire [23:0] addr_word = {page_sel[7:1], addr_cnt_r, 1'b0}; // R02 R03 R05
	wire [23:0] addr_byte = {page_sel, addr_cnt_r}; // R01 R05
	wire [23:0] addr_w    = word_lvl ? addr_word : addr_byte;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_r    <= ST_IDLE;
			cnt_r      <= 7'h00;
			addr_cnt_r <= 16'h0000;
			mem_r      <= '0;
			src_prev_r <= 1'b0;
			pend_r     <= 1'b0;
			ack_n_r    <= 1'b1;
		end
		else
		begin
			state_r    <= state_nxt;
			cnt_r      <= grant ? XFER_CYC - 7'h01 : (fin ? cnt_r : cnt_r - 7'h01); // R16
			src_prev_r <= req_src;
			// Carry stays inside 16 bits; page is never touched
			if (ADDR_LOAD)
				addr_cnt_r <= ADDR_BASE;
			else if (fin)
				addr_cnt_r <= addr_cnt_r + 16'h0001; // R04
			mem_r.wr   <= fin;
			if (fin)
			begin
				mem_r.word <= word_lvl;
				mem_r.addr <= addr_w;
				mem_r.data <= word_lvl ? f_data : {8'h00, f_data[7:0]};
			end
			// Request held while masked; new edge beats the clear
			pend_r  <= req_edge || (pend_r && !grant); // R14
			ack_n_r <= req_edge ? 1'b0 : (fin ? 1'b1 : ack_n_r); // R18
		end
	end

	assign MEM                        = mem_r;
	assign TRANSFER_ACKNOWLEDGE_OUT_N = ack_n_r;
	assign DREQ_O                     = pend_r;
	assign DREQ_OE_N                  = !dma_en; // R12

	// ----------------------------------------
	// Data buffer
	// ----------------------------------------
	dpx_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.clk       (MCLK),
		.rst       (RST),
		.in_valid  (PERIPH_VALID),
		.in_data   (PERIPH_DATA),
		.in_ready  (PERIPH_READY),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (fin)
	);

	// ----------------------------------------
	// Read back
	// ----------------------------------------
	logic [7:0] rdata_r;
	wire  [7:0] stat_w = {3'h0, f_valid, pend_r, state_r};
	// Pages read back, though software is told not to count on it
	wire  [7:0] rd_mux = rd_dec[3] ? page_w[rd_dec[2:0]] : // R09
		(IO_REQ.addr == IO_CTRL) ? ctrl_r :
		(IO_REQ.addr == IO_STAT) ? stat_w : 8'h00;

	always_ff @(posedge MCLK)
	begin
		if (RST)
			rdata_r <= 8'h00;
		else if (IO_REQ.rd)
			rdata_r <= rd_mux;
	end

	assign IO_RDATA = rdata_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_byte_addr;
		@(posedge MCLK) disable iff (RST)
		(fin && !word_lvl && !IO_REQ.wr) |=> MEM.wr
			&& MEM.addr == {$past(page_sel), $past(addr_cnt_r)};
	endproperty
	a_byte_addr: assert property (p_byte_addr) else $error("byte address wrong"); // R01

	property p_word_addr;
		@(posedge MCLK) disable iff (RST)
		(fin && word_lvl && !IO_REQ.wr) |=> MEM.wr && !MEM.addr[0]
			&& MEM.addr[16:1] == $past(addr_cnt_r)
			&& MEM.addr[23:17] == $past(page_sel[7:1]);
	endproperty
	a_word_addr: assert property (p_word_addr) else $error("word address wrong"); // R02 R03

	property p_wrap;
		@(posedge MCLK) disable iff (RST)
		(fin && !ADDR_LOAD && !IO_REQ.wr) |=>
			addr_cnt_r == $past(addr_cnt_r) + 16'h0001 && $stable(pages_flat);
	endproperty
	a_wrap: assert property (p_wrap) else $error("carry reached page"); // R04

	property p_page_wr;
		@(posedge MCLK) disable iff (RST)
		page_wr |=> page_w[$past(wr_dec[2:0])] == $past(IO_REQ.wdata);
	endproperty
	a_page_wr: assert property (p_page_wr) else $error("page write lost"); // R07 R08

	property p_page_hold;
		@(posedge MCLK) disable iff (RST)
		!page_wr |=> $stable(pages_flat) && page_w[4] == 8'h00;
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("page changed"); // R21 R06

	property p_float;
		@(posedge MCLK) disable iff (RST)
		ctrl_wr |=> DREQ_OE_N == !$past(IO_REQ.wdata[CTRL_EN_BIT]);
	endproperty
	a_float: assert property (p_float) else $error("request driven while off"); // R12

	property p_masked;
		@(posedge MCLK) disable iff (RST)
		(pend_r && ch_mask && state_r == ST_IDLE && !ctrl_wr) |=> pend_r && !HOLD_REQ;
	endproperty
	a_masked: assert property (p_masked) else $error("masked request lost"); // R14

	property p_hold;
		@(posedge MCLK) disable iff (RST)
		(state_r == ST_HOLD && !HOLD_ACK) |=> state_r == ST_HOLD && HOLD_REQ;
	endproperty
	a_hold: assert property (p_hold) else $error("transfer before grant"); // R15

	// Grant to write strobe: 70 transfer cycles plus output register
	property p_len;
		@(posedge MCLK) disable iff (RST)
		grant |=> (state_r == ST_XFER)[*8] ##62 fin ##1 MEM.wr;
	endproperty
	a_len: assert property (p_len) else $error("transfer length wrong"); // R16

	property p_timer;
		@(posedge MCLK) disable iff (RST)
		(timer_mode && TIMER_OUT && !src_prev_r) |=> pend_r && !TRANSFER_ACKNOWLEDGE_OUT_N;
	endproperty
	a_timer: assert property (p_timer) else $error("timer edge missed"); // R17 R18

	property p_ack_end;
		@(posedge MCLK) disable iff (RST)
		(fin && !req_edge) |=> TRANSFER_ACKNOWLEDGE_OUT_N;
	endproperty
	a_ack_end: assert property (p_ack_end) else $error("acknowledge not released"); // R18

endmodule // dpx_page_dma
`default_nettype wire

// ==== verilog/dpx_pkg.sv ====
`default_nettype none
package dpx_pkg;

	// ----------------------------------------
	// I/O locations
	// ----------------------------------------
	localparam logic [15:0] IO_PAGE_L0 = 16'h0087;
	localparam logic [15:0] IO_PAGE_L1 = 16'h0083;
	localparam logic [15:0] IO_PAGE_L2 = 16'h0081;
	localparam logic [15:0] IO_PAGE_L3 = 16'h0082;
	localparam logic [15:0] IO_PAGE_L5 = 16'h008B;
	localparam logic [15:0] IO_PAGE_L6 = 16'h0089;
	localparam logic [15:0] IO_PAGE_L7 = 16'h008A;
	localparam logic [15:0] IO_CTRL    = 16'h0300;
	localparam logic [15:0] IO_STAT    = 16'h0301;

	// ----------------------------------------
	// Control fields and reset values
	// ----------------------------------------
	localparam int          CTRL_EN_BIT    = 7;
	localparam int          CTRL_TIMER_BIT = 4;
	localparam int          CTRL_MASK_BIT  = 3;
	localparam int          CTRL_LVL_LSB   = 0;
	localparam logic [7:0]  CTRL_RESET     = 8'h08;
	localparam logic [7:0]  PAGE_RESET     = 8'h00;
	localparam logic [2:0]  CASCADE_LEVEL  = 3'h4;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_HZ        = 40_000_000;
	localparam int          DMA_CLK_HZ    = 3_000_000;
	localparam int          XFER_DMA_CLKS = 5;
	localparam int          DMA_CLK_CYC   = (CLK_HZ + DMA_CLK_HZ - 1) / DMA_CLK_HZ;
	localparam logic [6:0]  XFER_CYC      = 7'(XFER_DMA_CLKS * DMA_CLK_CYC);

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_HOLD = 3'h2,
		ST_XFER = 3'h4
	} dpx_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} dpx_io_t;

	typedef struct packed {
		logic        wr;
		logic        word;
		logic [23:0] addr;
		logic [15:0] data;
	} dpx_mem_t;

	// Hit flag and level of a page location
	function automatic logic [3:0] dpx_io_level(input logic [15:0] a);
		case (a)
			IO_PAGE_L0: dpx_io_level = 4'h8;
			IO_PAGE_L1: dpx_io_level = 4'h9;
			IO_PAGE_L2: dpx_io_level = 4'hA;
			IO_PAGE_L3: dpx_io_level = 4'hB;
			IO_PAGE_L5: dpx_io_level = 4'hD;
			IO_PAGE_L6: dpx_io_level = 4'hE;
			IO_PAGE_L7: dpx_io_level = 4'hF;
			default:    dpx_io_level = 4'h0;
		endcase
	endfunction

endpackage
`default_nettype wire

// ==== verilog/dpx_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpx_fifo
	import dpx_pkg::*;
#(
	parameter int W = 16,
	parameter int D = 16
) (
	// ----------------------------------------
	// Clock and reset
	// ----------------------------------------
	input  wire logic         clk,
	input  wire logic         rst,
	// ----------------------------------------
	// Fill side
	// ----------------------------------------
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// ----------------------------------------
	// Drain side
	// ----------------------------------------
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          ov_r;
	logic [W-1:0]  od_r;

	wire push = in_valid && in_ready;
	wire load = (cnt_r != '0) && (!ov_r || out_ready);

	// Output register counts toward the depth, so D words in all
	assign in_ready  = (cnt_r + (AW+1)'(ov_r)) != (AW+1)'(D);
	assign out_valid = ov_r;
	assign out_data  = od_r;

	// Head word held in a register so the read is clean
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
		if (load)
			od_r <= mem[rp_r];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			ov_r  <= 1'b0;
		end
		else
		begin
			wp_r  <= push ? wp_r + 1'b1 : wp_r;
			rp_r  <= load ? rp_r + 1'b1 : rp_r;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
			ov_r  <= load || (ov_r && !out_ready);
		end
	end

endmodule // dpx_fifo
`default_nettype wire

// ==== testbench/dpx_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dpx_host_model
	import dpx_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Hold handshake
	input  wire logic hold_req,
	input  wire logic slow,
	output logic      hold_ack
);
	// ----------------------------------------
	// Processor bus grant
	// ----------------------------------------
	logic [3:0] wait_r;
	logic       due;
	// Slow mode stands for a bus cycle still in flight
	assign due = (wait_r == (slow ? 4'h5 : 4'h1));
	always_ff @(posedge mclk)
	begin
		if (rst || !hold_req)
		begin
			wait_r   <= 4'h0;
			hold_ack <= 1'b0;
		end
		else if (due)
			hold_ack <= 1'b1;
		else
			wait_r   <= wait_r + 4'h1;
	end
endmodule // dpx_host_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dpx_pkg::*;
;
	logic        mclk, rst, addr_load, hold_req, hold_ack, dreq_o, dreq_oe_n;
	logic        timer_out, req_in, ack_n, p_valid, p_ready, slow;
	logic [15:0] addr_base, p_data;
	logic [7:0]  io_rdata, d8, v5;
	logic [23:0] a;
	logic [15:0] d;
	dpx_io_t     io;
	dpx_mem_t    mem;
	int          failures, comparisons, n, cyc, k;
	logic [15:0] pg [7] = '{IO_PAGE_L0, IO_PAGE_L1, IO_PAGE_L2, IO_PAGE_L3,
		IO_PAGE_L5, IO_PAGE_L6, IO_PAGE_L7};

	dpx_page_dma #(.FIFO_W(16), .FIFO_D(16)) u_dpx_page_dma (
		.MCLK(mclk), .RST(rst), .IO_REQ(io), .IO_RDATA(io_rdata),
		.ADDR_LOAD(addr_load), .ADDR_BASE(addr_base), .HOLD_REQ(hold_req),
		.HOLD_ACK(hold_ack), .DREQ_O(dreq_o), .DREQ_OE_N(dreq_oe_n), .MEM(mem),
		.TIMER_OUT(timer_out), .TRANSFER_REQUEST_IN(req_in),
		.TRANSFER_ACKNOWLEDGE_OUT_N(ack_n), .PERIPH_VALID(p_valid),
		.PERIPH_DATA(p_data), .PERIPH_READY(p_ready));
	dpx_host_model u_dpx_host_model (.mclk(mclk), .rst(rst), .hold_req(hold_req),
		.slow(slow), .hold_ack(hold_ack));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string m);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, m, seen, exp);
		end
	endtask
	task automatic io_wr(input logic [15:0] ad, input logic [7:0] v);
		io = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: v};
		tick();
		io.wr = 1'b0;
		// Idle edge so the next access never reassigns the strobe at once
		tick();
	endtask
	task automatic io_rd(input logic [15:0] ad, output logic [7:0] v);
		io = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
		tick();
		io.rd = 1'b0;
		v = io_rdata;
		tick();
	endtask
	task automatic load(input logic [15:0] b);
		addr_load = 1'b1;
		addr_base = b;
		tick();
		addr_load = 1'b0;
	endtask
	// Kick 0 none, 1 peripheral request, 2 timer; cycles counted from grant
	task automatic xfer(input int kick);
		logic ack;
		int   g;
		g = 0;
		if (kick == 1) req_in = 1'b1;
		if (kick == 2) timer_out = 1'b1;
		if (kick != 0) tick();
		req_in = 1'b0;
		timer_out = 1'b0;
		for (n = 1; n <= 300; n++)
		begin
			ack = hold_ack;
			tick();
			if (ack && g == 0) g = n;
			if (mem.wr === 1'b1) break;
		end
		if (n > 300)
		begin
			failures++;
			$display("CHECK FAILED at %0t: no transfer", $time);
			close_out();
		end
		cyc = n - g;
		a = mem.addr;
		d = mem.data;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		failures = 0;
		comparisons = 0;
		rst = 1'b1;
		io = '0;
		{addr_load, timer_out, req_in, p_valid, slow} = 5'h00;
		addr_base = 16'h0000;
		p_data = 16'h0000;
		repeat (3) tick();
		rst = 1'b0;
		check(dreq_oe_n, 1, "float");
		check(ack_n, 1, "ack idle");
		for (int i = 0; i < 7; i++)
		begin
			io_rd(pg[i], d8);
			check(d8, 0, "page reset");
			io_wr(pg[i], {pg[i][3:0], 4'h5});
			io_rd(pg[i], d8);
			check(d8, {pg[i][3:0], 4'h5}, "page rw");
		end
		io_rd(16'h0084, d8);
		check(d8, 0, "no level 4 page");
		// Fill until refused
		p_valid = 1'b1;
		for (k = 0; p_ready === 1'b1 && k < 20; k++)
		begin
			p_data = 16'hA000 + 16'(k);
			tick();
		end
		p_valid = 1'b0;
		check(24'(k), 24'd16, "fifo depth");
		io_wr(IO_CTRL, 8'h0A);
		load(16'hFFFF);
		io_wr(IO_PAGE_L2, 8'h15);
		req_in = 1'b1;
		tick();
		req_in = 1'b0;
		repeat (4) tick();
		check(hold_req, 0, "masked hold");
		check(ack_n, 0, "ack low");
		check(dreq_oe_n, 1, "still float");
		io_rd(IO_STAT, d8);
		check(d8, 8'h19, "pending kept");
		io_wr(IO_CTRL, 8'h8A);
		check({dreq_oe_n, dreq_o}, 2'b01, "driven");
		check(hold_req, 0, "enabled masked");
		io_wr(IO_CTRL, 8'h82);
		check(hold_req, 1, "hold now");
		xfer(0);
		check(cyc, 24'(XFER_CYC), "length");
		check(mem.word, 0, "byte flag");
		check(a, {8'h15, 16'hFFFF}, "byte addr");
		check(d[7:0], 8'h00, "byte data");
		check(ack_n, 1, "ack done");
		xfer(1);
		check(a, {8'h15, 16'h0000}, "wrap in page");
		check(d[7:0], 8'h01, "byte data");
		io_rd(IO_PAGE_L2, d8);
		check(d8, 8'h15, "page kept");
		// Word level, timer paced, slow grant, drain to empty
		v5 = 8'hB5;
		io_wr(IO_CTRL, 8'h95);
		load(16'h8001);
		slow = 1'b1;
		for (int j = 2; j < 16; j++)
		begin
			xfer(2);
			check(a, {v5[7:1], 16'(32'h8001 + j - 2), 1'b0}, "word addr");
			check(d, 16'hA000 + 16'(j), "word data");
			check(cyc, 24'(XFER_CYC), "slow length");
			check(mem.word, 1, "word flag");
		end
		io_rd(IO_STAT, d8);
		check(d8, 8'h01, "drained");
		// Cascade level never asks for the bus, even with data waiting
		p_valid = 1'b1;
		p_data = 16'h00C4;
		tick();
		p_valid = 1'b0;
		io_wr(IO_CTRL, 8'h84);
		req_in = 1'b1;
		tick();
		req_in = 1'b0;
		repeat (2) tick();
		check(hold_req, 0, "cascade no hold");
		check(dreq_o, 1, "cascade pending");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
